// File: rtl/sws_engine.sv
// Write-same fill engine: takes a key sector, checks it, receives sector
// data into a FIFO, walks the media one block at a time and reports status.
// Assumes a media port that acks each block write and a buffer that drains
// the FIFO and repeats the received data; new commands arrive as pulses.
`timescale 1ns/10ps
`default_nettype none
module sws_engine (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_arst_n,
    input  wire logic                       i_key_vld,
    input  wire logic [sws_pkg::WORD_W-1:0] i_key_word,
    input  wire logic                       i_key_last,
    output logic                            o_key_rdy,
    input  wire logic                       i_dat_vld,
    input  wire logic [sws_pkg::WORD_W-1:0] i_dat,
    output logic                            o_dat_rdy,
    output logic                            o_buf_vld,
    output logic [sws_pkg::WORD_W-1:0]      o_buf_dat,
    input  wire logic                       i_buf_rdy,
    input  wire logic [sws_pkg::LBA_W-1:0]  i_last_user_lba,
    input  wire logic                       i_cmd_new,
    input  wire logic                       i_cmd_is_status,
    input  wire logic                       i_host_wr,
    input  wire logic                       i_read_realloc,
    output logic                            o_med_req,
    output logic [sws_pkg::LBA_W-1:0]       o_med_lba,
    output logic                            o_med_pat_mode,
    output logic [31:0]                     o_med_pat,
    input  wire logic                       i_med_ack,
    input  wire logic                       i_med_err,
    output logic                            o_tf_vld,
    output logic [7:0]                      o_tf_err,
    output logic [7:0]                      o_tf_cnt,
    output logic [7:0]                      o_tf_num,
    output logic [7:0]                      o_tf_cyl_lo,
    output logic [7:0]                      o_tf_cyl_hi,
    output logic [7:0]                      o_tf_stat,
    output logic [15:0]                     o_ext_status,
    output logic [15:0]                     o_last_func,
    output logic [sws_pkg::LBA_W-1:0]       o_cur_lba,
    output logic [7:0]                      o_drv_state,
    output logic                            o_seg_init
);
    import sws_pkg::*;

    typedef struct packed {
        sws_state_t         st;
        logic [7:0]         widx;
        logic [15:0]        act;
        logic [15:0]        fn;
        logic [LBA_W-1:0]   start;
        logic [LBA_W-1:0]   cnt;
        logic [31:0]        pat;
        logic [LBA_W-1:0]   plen;
        logic [LBA_W-1:0]   cur;
        logic [LBA_W-1:0]   last;
        logic [REM_W-1:0]   rem;
        logic               bg;
        logic               full;
        logic [15:0]        ext;
        logic               seg;
        logic               tf_vld;
        logic [7:0]         tf_err;
        logic [7:0]         tf_cnt;
        logic [7:0]         tf_num;
        logic [7:0]         tf_clo;
        logic [7:0]         tf_chi;
        logic [7:0]         tf_stat;
    } sws_regs_t;

    sws_regs_t r_q;
    sws_regs_t r_d;

    logic             rng_ok;
    logic [LBA_W-1:0] rng_end;
    logic             fifo_in_rdy;
    logic             dat_take;
    logic             fn_known;
    logic             fn_pattern;
    logic             fn_bg;
    logic             bg_kill;
    logic             fill_done;
    logic             seg_set;

    sws_range_chk u_rng (
        .i_start (r_q.start),
        .i_count (r_q.cnt),
        .i_last  (i_last_user_lba),
        .o_ok    (rng_ok),
        .o_end   (rng_end)
    );

    // Sector data passes through the FIFO; a stalled buffer stalls the host.
    sws_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_in_vld  (dat_take),
        .i_in_dat  (i_dat),
        .o_in_rdy  (fifo_in_rdy),
        .o_out_vld (o_buf_vld),
        .o_out_dat (o_buf_dat),
        .i_out_rdy (i_buf_rdy)
    );

    // Function decode; the multi-sector variant is treated as background.
    assign fn_pattern = (r_q.fn == FN_BG_PATTERN) || (r_q.fn == FN_BLK_PATTERN);
    assign fn_bg = (r_q.fn == FN_BG_PATTERN) || (r_q.fn == FN_BG_SECTOR) ||
                   (r_q.fn == FN_BG_MULTI);
    assign fn_known = fn_bg || (r_q.fn == FN_BLK_PATTERN) || (r_q.fn == FN_BLK_SECTOR);

    // Handshakes are combinational from state.
    assign o_key_rdy = (r_q.st == SWS_IDLE) || (r_q.st == SWS_KEY);
    assign o_dat_rdy = (r_q.st == SWS_RECV) && fifo_in_rdy;
    assign dat_take = o_dat_rdy && i_dat_vld;
    assign o_med_req = (r_q.st == SWS_FILL);

    // A status request passes through a background fill untouched.
    assign bg_kill = (r_q.st == SWS_FILL) && r_q.bg && i_cmd_new && !i_cmd_is_status;
    assign fill_done = (r_q.st == SWS_FILL) && i_med_ack && !i_med_err && !bg_kill &&
                       (r_q.cur == r_q.last);
    assign seg_set = fill_done && r_q.full;

    always_comb begin
        r_d = r_q;
        r_d.tf_vld = 1'b0;
        // Host writes clear the flag; a clean whole-drive fill sets it and
        // wins when both land in one cycle. Read reallocations are ignored.
        if (i_host_wr && !i_read_realloc) begin
            r_d.seg = 1'b0;
        end
        case (r_q.st)
            SWS_IDLE, SWS_KEY: begin
                if (i_key_vld) begin
                    r_d.st = i_key_last ? SWS_CHECK : SWS_KEY;
                    r_d.widx = (r_q.widx == 8'hFF) ? r_q.widx : r_q.widx + 8'h01;
                    // Each key word lands in its field, low word first.
                    case (r_q.widx)
                        KW_ACTION: r_d.act = i_key_word;
                        KW_FUNCTION: r_d.fn = i_key_word;
                        KW_START, KW_START + 8'h01, KW_START + 8'h02, KW_START + 8'h03: begin
                            r_d.start[16*(r_q.widx - KW_START) +: 16] = i_key_word;
                        end
                        KW_COUNT, KW_COUNT + 8'h01, KW_COUNT + 8'h02, KW_COUNT + 8'h03: begin
                            r_d.cnt[16*(r_q.widx - KW_COUNT) +: 16] = i_key_word;
                        end
                        KW_PATTERN, KW_PATTERN + 8'h01: begin
                            r_d.pat[16*(r_q.widx - KW_PATTERN) +: 16] = i_key_word;
                        end
                        KW_PLEN, KW_PLEN + 8'h01, KW_PLEN + 8'h02, KW_PLEN + 8'h03: begin
                            r_d.plen[16*(r_q.widx - KW_PLEN) +: 16] = i_key_word;
                        end
                        default: begin
                        end
                    endcase
                    if (r_q.st == SWS_IDLE) begin
                        r_d.widx = 8'h01;
                        r_d.act = i_key_word;
                    end
                end
            end
            SWS_CHECK: begin
                r_d.widx = 8'h00;
                r_d.st = SWS_IDLE;
                if (r_q.act != ACT_WRITE_SAME) begin
                    // Other actions belong to other handlers; stay silent.
                    r_d.st = SWS_IDLE;
                end else if (!fn_known) begin
                    r_d.ext = EXT_BAD_FUNC;
                    r_d.tf_vld = 1'b1;
                    r_d.tf_err = TF_ERR_ABORT;
                    r_d.tf_cnt = EXT_BAD_FUNC[7:0];
                    r_d.tf_num = EXT_BAD_FUNC[15:8];
                    r_d.tf_stat = TF_STAT_ERR;
                end else if (!rng_ok) begin
                    r_d.ext = EXT_BAD_RANGE;
                    r_d.tf_vld = 1'b1;
                    r_d.tf_err = TF_ERR_ABORT;
                    r_d.tf_cnt = EXT_BAD_RANGE[7:0];
                    r_d.tf_num = EXT_BAD_RANGE[15:8];
                    r_d.tf_stat = TF_STAT_ERR;
                end else begin
                    r_d.cur = r_q.start;
                    r_d.last = rng_end;
                    r_d.full = (r_q.start == '0) && (rng_end == i_last_user_lba);
                    r_d.bg = fn_bg;
                    r_d.ext = fn_bg ? EXT_RUNNING : r_q.ext;
                    r_d.rem = (r_q.fn == FN_BG_MULTI) ?
                              {r_q.plen[REM_W-9:0], 8'h00} : SECTOR_WORDS;
                    r_d.st = fn_pattern ? SWS_FILL : SWS_RECV;
                    // A pattern fill has no data phase, so background ends now.
                    if (fn_pattern && fn_bg) begin
                        r_d.tf_vld = 1'b1;
                        r_d.tf_err = TF_ERR_NONE;
                        r_d.tf_clo = TF_XFER_LO;
                        r_d.tf_chi = TF_XFER_HI;
                        r_d.tf_stat = TF_STAT_OK;
                    end
                end
            end
            SWS_RECV: begin
                if (dat_take) begin
                    r_d.rem = r_q.rem - 1'b1;
                    if (r_q.rem <= {{(REM_W-1){1'b0}}, 1'b1}) begin
                        r_d.st = SWS_FILL;
                        if (r_q.bg) begin
                            r_d.tf_vld = 1'b1;
                            r_d.tf_err = TF_ERR_NONE;
                            r_d.tf_clo = TF_XFER_LO;
                            r_d.tf_chi = TF_XFER_HI;
                            r_d.tf_stat = TF_STAT_OK;
                        end
                    end
                end
            end
            SWS_FILL: begin
                if (bg_kill) begin
                    r_d.ext = EXT_BG_ABORTED;
                    r_d.st = SWS_IDLE;
                end else if (i_med_err) begin
                    r_d.ext = r_q.bg ? EXT_BG_MEDIA : EXT_BLK_MEDIA;
                    r_d.st = SWS_IDLE;
                    if (!r_q.bg) begin
                        r_d.tf_vld = 1'b1;
                        r_d.tf_err = TF_ERR_ABORT;
                        r_d.tf_cnt = EXT_BLK_MEDIA[7:0];
                        r_d.tf_num = EXT_BLK_MEDIA[15:8];
                        r_d.tf_stat = TF_STAT_ERR;
                    end
                end else if (i_med_ack) begin
                    // Every written block is a user write and drops the flag, so a whole-drive fill cut
                    // after its first acked block leaves it clear; the final ack sets it below.
                    r_d.seg = 1'b0;
                    if (fill_done) begin
                        r_d.ext = EXT_OK;
                        r_d.st = SWS_IDLE;
                        if (!r_q.bg) begin
                            r_d.tf_vld = 1'b1;
                            r_d.tf_err = TF_ERR_NONE;
                            r_d.tf_clo = TF_XFER_LO;
                            r_d.tf_chi = TF_XFER_HI;
                            r_d.tf_stat = TF_STAT_OK;
                        end
                    end else begin
                        r_d.cur = r_q.cur + 1'b1;
                    end
                end
            end
            default: begin
                r_d.st = SWS_IDLE;
            end
        endcase
        if (seg_set) begin
            r_d.seg = 1'b1;
        end
    end

    // Single state register; everything resets to an idle, clean engine.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // All data outputs but the buffer data come from the state register.
    assign o_med_lba = r_q.cur;
    assign o_med_pat_mode = fn_pattern;
    assign o_med_pat = r_q.pat;
    assign o_tf_vld = r_q.tf_vld;
    assign o_tf_err = r_q.tf_err;
    assign o_tf_cnt = r_q.tf_cnt;
    assign o_tf_num = r_q.tf_num;
    assign o_tf_cyl_lo = r_q.tf_clo;
    assign o_tf_cyl_hi = r_q.tf_chi;
    assign o_tf_stat = r_q.tf_stat;
    assign o_ext_status = r_q.ext;
    assign o_last_func = r_q.fn;
    assign o_cur_lba = r_q.cur;
    assign o_drv_state = ((r_q.st == SWS_FILL) && r_q.bg) ? DRV_BG_SCT : DRV_ACTIVE;
    assign o_seg_init = r_q.seg;

    property p_tf_ok;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_tf_vld && o_tf_stat == 8'h50) |->
            (o_tf_err == 8'h00 && o_tf_cyl_lo == 8'h01 && o_tf_cyl_hi == 8'h00);
    endproperty
    a_tf_ok: assert property (p_tf_ok) else $error("success answer fields wrong");

    property p_tf_err;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_tf_vld && o_tf_stat != 8'h50) |->
            (o_tf_stat == 8'h51 && o_tf_err == 8'h04 && {o_tf_num, o_tf_cnt} == o_ext_status);
    endproperty
    a_tf_err: assert property (p_tf_err) else $error("error answer fields wrong");

    property p_bg_running;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_drv_state == 8'h05) |-> (o_ext_status == 16'hFFFF && o_med_req);
    endproperty
    a_bg_running: assert property (p_bg_running) else $error("background status wrong");

    property p_drv;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_med_req && o_ext_status == 16'hFFFF) |-> (o_drv_state == 8'h05);
    endproperty
    a_drv: assert property (p_drv) else $error("drive status not 5 in background");

    property p_abort;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_drv_state == 8'h05 && i_cmd_new && !i_cmd_is_status) |=>
            (!o_med_req && o_ext_status == 16'h0008 && !o_tf_vld);
    endproperty
    a_abort: assert property (p_abort) else $error("interrupting command not honoured");

    property p_blk_err;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_med_req && !r_q.bg && i_med_err) |=>
            (o_tf_vld && o_ext_status == 16'h0017 && !o_med_req);
    endproperty
    a_blk_err: assert property (p_blk_err) else $error("blocking media error not reported");

    property p_lba_inc;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_med_req && i_med_ack && !i_med_err && !i_cmd_new && o_med_lba != r_q.last) |=>
            (o_med_req && o_med_lba == $past(o_med_lba) + 64'h1);
    endproperty
    a_lba_inc: assert property (p_lba_inc) else $error("fill address not ascending");

    property p_blk_hold;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (o_med_req && !r_q.bg) |-> !o_tf_vld;
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("blocking completion too early");

    property p_seg;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_host_wr && !i_read_realloc && !seg_set) |=> !o_seg_init;
    endproperty
    a_seg: assert property (p_seg) else $error("host write left flag set");
endmodule
`default_nettype wire

// File: rtl/sws_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; a full FIFO drops its input ready so the source stalls.
`timescale 1ns/10ps
`default_nettype none
module sws_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_in_vld,
    input  wire logic [WIDTH-1:0] i_in_dat,
    output logic                  o_in_rdy,
    output logic                  o_out_vld,
    output logic      [WIDTH-1:0] o_out_dat,
    input  wire logic             i_out_rdy
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign o_in_rdy = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_vld = (cnt_q != '0);
    assign o_out_dat = mem_q[rp_q];
    assign push = i_in_vld && o_in_rdy;
    assign pop = o_out_vld && i_out_rdy;

    // Pointers wrap by index; depth is a power of two.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; only written entries are ever read.
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wp_q] <= i_in_dat;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sws_pkg.sv
// Constants, encodings and state type shared by the write-same fill engine.
// Assumes a single 10 MHz clock domain and key-sector words of 16 bits.
// How it works
// - Action code 0002h selects the write-same fill.
// - Function codes pick background or blocking variant.
// - Key words 5:2 start, 9:6 count.
// - Pattern fill writes 32-bit words 11-10 repeatedly.
// - Words 15-12 give multi-sector pattern length.
// - Acceptance returns error 00h, status 50h, count 1; the engine puts 1 in cylinder low and leaves count unchanged.
// - Sectors written ascending from start, stop at count.
// - Zero count fills through the last user block.
// - Never write beyond last user block into hidden area.
// - Out-of-range start or end aborts without writing.
// - Complete whole-drive fill sets segment-initialized flag.
// - Any other user sector write clears the flag.
// - Read-triggered reallocations leave the flag alone.
// - Background mode completes once data is received.
// - Any non-status command terminates a background fill.
// - Extended status FFFFh running, 0000h clean end.
// - Interrupted background gives 0008h, media error 0009h.
// - Blocking mode completes only after the fill ends.
// - Errors put extended status in count and number.
// - Blocking fill media error reports 0017h.
// - Status response carries the extended status word.
// - Status response carries the current fill address.
// - Drive status reads 5 during background fill.
package sws_pkg;

    localparam int LBA_W = 64;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int REM_W = 40;

    localparam logic [15:0] ACT_WRITE_SAME = 16'h0002;
    localparam logic [15:0] FN_BG_PATTERN = 16'h0001;
    localparam logic [15:0] FN_BG_SECTOR = 16'h0002;
    localparam logic [15:0] FN_BG_MULTI = 16'h0003;
    localparam logic [15:0] FN_BLK_PATTERN = 16'h0101;
    localparam logic [15:0] FN_BLK_SECTOR = 16'h0102;

    // Key-sector word positions.
    localparam logic [7:0] KW_ACTION = 8'h00;
    localparam logic [7:0] KW_FUNCTION = 8'h01;
    localparam logic [7:0] KW_START = 8'h02;
    localparam logic [7:0] KW_COUNT = 8'h06;
    localparam logic [7:0] KW_PATTERN = 8'h0A;
    localparam logic [7:0] KW_PLEN = 8'h0C;

    localparam logic [REM_W-1:0] SECTOR_WORDS = 40'h00_0000_0100;

    // Task-file answer values.
    localparam logic [7:0] TF_ERR_NONE = 8'h00;
    localparam logic [7:0] TF_ERR_ABORT = 8'h04;
    localparam logic [7:0] TF_STAT_OK = 8'h50;
    localparam logic [7:0] TF_STAT_ERR = 8'h51;
    localparam logic [7:0] TF_XFER_LO = 8'h01;
    localparam logic [7:0] TF_XFER_HI = 8'h00;

    // Extended status codes.
    localparam logic [15:0] EXT_OK = 16'h0000;
    localparam logic [15:0] EXT_RUNNING = 16'hFFFF;
    localparam logic [15:0] EXT_BG_ABORTED = 16'h0008;
    localparam logic [15:0] EXT_BG_MEDIA = 16'h0009;
    localparam logic [15:0] EXT_BLK_MEDIA = 16'h0017;
    localparam logic [15:0] EXT_BAD_FUNC = 16'h0004;
    localparam logic [15:0] EXT_BAD_RANGE = 16'h0005;

    localparam logic [7:0] DRV_ACTIVE = 8'h00;
    localparam logic [7:0] DRV_BG_SCT = 8'h05;

    typedef enum logic [2:0] {
        SWS_IDLE  = 3'b000,
        SWS_KEY   = 3'b001,
        SWS_CHECK = 3'b010,
        SWS_RECV  = 3'b011,
        SWS_FILL  = 3'b100
    } sws_state_t;

endpackage

// File: rtl/sws_range_chk.sv
// Range check of a requested fill against the last user block.
// Assumes the last user block already reflects the protected-area setting.
`timescale 1ns/10ps
`default_nettype none
module sws_range_chk (
    input  wire logic [sws_pkg::LBA_W-1:0] i_start,
    input  wire logic [sws_pkg::LBA_W-1:0] i_count,
    input  wire logic [sws_pkg::LBA_W-1:0] i_last,
    output logic                           o_ok,
    output logic [sws_pkg::LBA_W-1:0]      o_end
);
    import sws_pkg::*;

    logic [LBA_W:0] sum;
    logic [LBA_W:0] limit;

    // Widened by one bit so a huge count cannot wrap past the check.
    assign sum = {1'b0, i_start} + {1'b0, i_count};
    assign limit = {1'b0, i_last} + {{LBA_W{1'b0}}, 1'b1};
    assign o_ok = (i_start <= i_last) && ((i_count == '0) || (sum <= limit));
    // A zero count runs to the last user block and never past it.
    assign o_end = (i_count == '0) ? i_last : LBA_W'(sum - 1'b1);
endmodule
`default_nettype wire

// File: tb/sws_media_model.sv
// Media partner: acks block writes and drains the data buffer.
// Assumes the engine holds its media request for the whole fill.
`timescale 1ns/10ps
`default_nettype none
module sws_media_model (
    input  wire logic i_sys_clk,
    input  wire logic i_med_req,
    input  wire logic i_err_en,
    output logic      o_med_ack,
    output logic      o_med_err,
    output logic      o_buf_rdy
);
    logic tog = 1'b0;

    // Acks at half rate and a stalling buffer, so the engine never sees a prompt partner.
    always @(negedge i_sys_clk) begin
        o_med_ack <= i_med_req && !o_med_ack && !i_err_en;
        o_med_err <= i_med_req && i_err_en;
        tog <= !tog;
    end
    assign o_buf_rdy = tog;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the write-same fill engine.
// Assumes the engine and the media partner; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sws_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, kv = 1'b0, kl = 1'b0, dv = 1'b0, cn = 1'b0, cs = 1'b0;
    logic hw = 1'b0, rr = 1'b0, err_en = 1'b0, ack, merr, brdy, krdy, drdy, bvld, mreq, pm;
    logic tfv, seg;
    logic [15:0] kw = 16'h0000, dw = 16'h0000, ext, lf, bd, fn, seed = 16'h9D20;
    logic [63:0] last = 64'h0000000000000001, mlba, clba;
    logic [7:0] te, tc, tn, tl, th, ts, drv;
    logic [31:0] pat;
    int n_errors = 0, tests_run = 0;
    sws_engine dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_key_vld(kv), .i_key_word(kw),
        .i_key_last(kl), .o_key_rdy(krdy), .i_dat_vld(dv), .i_dat(dw), .o_dat_rdy(drdy),
        .o_buf_vld(bvld), .o_buf_dat(bd), .i_buf_rdy(brdy), .i_last_user_lba(last),
        .i_cmd_new(cn), .i_cmd_is_status(cs), .i_host_wr(hw), .i_read_realloc(rr),
        .o_med_req(mreq), .o_med_lba(mlba), .o_med_pat_mode(pm), .o_med_pat(pat),
        .i_med_ack(ack), .i_med_err(merr), .o_tf_vld(tfv), .o_tf_err(te), .o_tf_cnt(tc),
        .o_tf_num(tn), .o_tf_cyl_lo(tl), .o_tf_cyl_hi(th), .o_tf_stat(ts),
        .o_ext_status(ext), .o_last_func(lf), .o_cur_lba(clba), .o_drv_state(drv),
        .o_seg_init(seg));
    sws_media_model media (.i_sys_clk(clk), .i_med_req(mreq), .i_err_en(err_en),
        .o_med_ack(ack), .o_med_err(merr), .o_buf_rdy(brdy));
    // Free-running 10 MHz clock.
    always #50 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bounded wait on falling edges; a bound used up ends the run.
    task automatic wait_on(ref logic s, input logic v);
        for (int t = 0; s !== v; t++) begin
            if (t > 3000) begin
                n_errors++;
                finish_test();
            end
            @(negedge clk);
        end
    endtask
    // Sends the 16 key words; the multi-sector variant gets a two-sector pattern.
    task automatic key(input logic [15:0] f, input logic [63:0] st, c, input logic [31:0] p);
        logic [15:0] w [16];
        w = '{ACT_WRITE_SAME, f, st[15:0], st[31:16], st[47:32], st[63:48], c[15:0], c[31:16],
              c[47:32], c[63:48], p[15:0], p[31:16],
              (f == FN_BG_MULTI) ? 16'h0002 : 16'h0001, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            kv = 1'b1;
            kw = w[i];
            kl = (i == 15);
        end
        @(negedge clk);
        kv = 1'b0;
        kl = 1'b0;
    endtask
    // Streams n random words, holding each until it is taken.
    task automatic send_data(input int n);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            dv = 1'b1;
            dw = seed;
            wait_on(drdy, 1'b1);
            @(negedge clk);
            // The FIFO starts empty, so the first word heads it one edge after it is taken.
            if (i == 0) chk("buf_head", {1'b1, seed}, {bvld, bd});
        end
        dv = 1'b0;
    endtask
    // The qualifier is a ref so that it stands beside the strobe, not after it.
    task automatic pulse(ref logic s, input logic q, ref logic qs);
        qs = q;
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        key(FN_BG_PATTERN, 64'h0, 64'h0, 32'hA5C31E70);
        wait_on(tfv, 1'b1);
        chk("tf", {TF_ERR_NONE, TF_STAT_OK, TF_XFER_HI, TF_XFER_LO}, {te, ts, th, tl});
        chk("ext_run", {EXT_RUNNING, DRV_BG_SCT, 32'hA5C31E70}, {ext, drv, pat});
        chk("fill_rdy", {1'b0, 1'b1}, {krdy, pm});
        chk("lba0", 64'h0, clba | mlba);
        wait_on(mreq, 1'b0);
        @(negedge clk);
        chk("ext_ok_seg", {EXT_OK, 1'b1}, {ext, seg});
        pulse(hw, 1'b1, rr);
        chk("seg_realloc", 1'b1, seg);
        pulse(hw, 1'b0, rr);
        chk("seg_clear", 1'b0, seg);
        $display("pattern fill done");
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            fn = (i < 3) ? {seed[15:9], 9'h1F0} : FN_BLK_PATTERN;
            key(fn, (i == 3) ? last + 1 : 64'h0, (i == 4) ? last + 2 : 64'h1, 32'h0);
            wait_on(tfv, 1'b1);
            chk("err_tf", {TF_ERR_ABORT, TF_STAT_ERR, 2'b01}, {te, ts, mreq, krdy});
            chk("err_ext", (i < 3) ? EXT_BAD_FUNC : EXT_BAD_RANGE, {tn, tc});
        end
        $display("refusals done");
        last = 64'h3;
        key(FN_BG_PATTERN, 64'h1, 64'h0, 32'h0F0F0F0F);
        wait_on(tfv, 1'b1);
        pulse(cn, 1'b1, cs);
        chk("status_cmd", {EXT_RUNNING, 48'h2}, {ext, clba[47:0]});
        pulse(cn, 1'b0, cs);
        chk("aborted", {EXT_BG_ABORTED, DRV_ACTIVE}, {ext, drv});
        err_en = 1'b1;
        key(FN_BLK_PATTERN, 64'h0, 64'h1, 32'h0);
        wait_on(tfv, 1'b1);
        chk("blk_media", {TF_ERR_ABORT, EXT_BLK_MEDIA, EXT_BLK_MEDIA}, {te, tn, tc, ext});
        err_en = 1'b0;
        $display("aborts done");
        for (int i = 0; i < 3; i++) begin
            fn = (i == 0) ? FN_BG_SECTOR : (i == 1) ? FN_BLK_SECTOR : FN_BG_MULTI;
            key(fn, 64'h2, 64'h1, 32'h0);
            send_data((fn == FN_BG_MULTI) ? 512 : 256);
            wait_on(tfv, 1'b1);
            chk("sector_tf", {TF_STAT_OK, fn != FN_BLK_SECTOR}, {ts, mreq});
            chk("sector_fn", {fn, 1'b0}, {lf, pm});
            wait_on(mreq, 1'b0);
        end
        $display("sector fills done");
        finish_test();
    end
endmodule
`default_nettype wire
